// ### ude_endpoint_ctrl.sv
/*
 * control of one IN and one OUT data endpoint: packet handshake with
 * software, single/double buffering, auto-arm, auto-release, toggles,
 * queue discard and stall, registers on an AXI4-Lite slave.
 * assumes a link engine that reports tokens, acks and received packets
 * as one-cycle pulses and sends the answer given the next cycle.
 */
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "ude_cfg.svh"

// Notes on behaviour
// - auto_arm arms the IN packet once a limit-sized packet is loaded.
// - iso bit selects bulk/interrupt (0) or isochronous (1) protocol.
// - with force off the IN toggle advances only on host ack.
// - with force on the IN toggle advances on every non-iso packet sent.
// - toggle_restart on IN returns its toggle to DATA0.
// - in_queue_nonempty shows queued data; queue_discard drops one packet.
// - armed IN packet goes out on a token; armed clears, event raised.
// - double buffering when size limit is at most half the FIFO space.
// - double buffered, first armed packet clears armed at once, event.
// - arming with nothing loaded sends a zero-length packet.
// - IN stall_request answers the next token with STALL, flags it.
// - auto_release frees the OUT packet once limit bytes are read.
// - bit 7 of OUT control b enables auto_release.
// - OUT toggle_restart zeroes toggle; discard drops one waiting packet.
// - received OUT packet sets out_packet_waiting, event, byte count.
// - OUT stall_request answers the next packet with STALL, flags it.
// - interrupt endpoints behave as bulk ones, force toggle aside.
// - iso IN with auto_arm arms on exactly a limit-sized packet.
// - in_packet_armed sits at IN control a bit 0, set by auto_arm.
module ude_endpoint_ctrl #(
    parameter int SW = 11,
    parameter int IN_FIFO_BYTES = 64,
    parameter int OUT_FIFO_BYTES = 64
)(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // fifo byte strobes from the software side
    input wire logic in_fifo_wr,
    input wire logic out_fifo_rd,
    // IN link
    input wire logic in_token,
    input wire logic in_ack,
    output ude_pkg::ude_resp_t in_resp,
    output logic in_resp_pid,
    output logic [SW-1:0] in_resp_len,
    // OUT link
    input wire logic out_rx_done,
    input wire logic out_rx_pid,
    input wire logic [SW-1:0] out_rx_len,
    output ude_pkg::ude_resp_t out_resp,
    output logic out_keep,
    // endpoint events, gated by endpoint_irq_enable
    output logic in_ep_event,
    output logic out_ep_event
);
    import ude_pkg::*;

    function automatic logic fits_two(input logic [SW-1:0] lim,
                                      input int space);
        return {1'b0, lim, 1'b0} <= (SW+2)'(space);
    endfunction

    // bus state
    logic aw_full, w_full;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    // register contents
    logic [SW-1:0] in_limit, out_limit;
    logic in_auto, in_iso, in_force, in_stall_req, in_stall_done;
    logic out_auto, out_iso, out_stall_req, out_stall_done;
    logic [1:0] irq_en;
    // IN endpoint state
    logic [1:0] in_cnt;
    logic in_head, in_armed, in_toggle, in_sent;
    logic [SW-1:0] in_load;
    logic [SW-1:0] in_len [2];
    // OUT endpoint state
    logic [1:0] out_cnt;
    logic out_head, out_toggle;
    logic [SW-1:0] out_unload;
    logic [SW-1:0] out_len [2];

    // bus decode
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire wr_go = aw_full && w_full;
    wire lo = wstrb_q[0];
    wire hi = wstrb_q[1];
    wire wr_in_limit = wr_go && waddr_q == `UDE_OFS_IN_LIMIT;
    wire wr_in_a = wr_go && lo && waddr_q == `UDE_OFS_IN_A;
    wire wr_in_b = wr_go && lo && waddr_q == `UDE_OFS_IN_B;
    wire wr_out_limit = wr_go && waddr_q == `UDE_OFS_OUT_LIMIT;
    wire wr_out_a = wr_go && lo && waddr_q == `UDE_OFS_OUT_A;
    wire wr_out_b = wr_go && lo && waddr_q == `UDE_OFS_OUT_B;
    wire wr_irq = wr_go && lo && waddr_q == `UDE_OFS_IRQ_EN;
    wire wr_hit = waddr_q == `UDE_OFS_IN_LIMIT
        || waddr_q == `UDE_OFS_IN_A || waddr_q == `UDE_OFS_IN_B
        || waddr_q == `UDE_OFS_OUT_LIMIT || waddr_q == `UDE_OFS_OUT_A
        || waddr_q == `UDE_OFS_OUT_B || waddr_q == `UDE_OFS_IRQ_EN
        || waddr_q == `UDE_OFS_OUT_CNT_LO
        || waddr_q == `UDE_OFS_OUT_CNT_HI;
    wire in_restart = wr_in_a && wdata_q[`UDE_IN_RESTART];
    wire out_restart = wr_out_a && wdata_q[`UDE_OUT_RESTART];

    // IN packet bookkeeping
    wire in_dbl = fits_two(in_limit, IN_FIFO_BYTES);
    wire [1:0] in_cap = in_dbl ? 2'd2 : 2'd1;
    wire in_room = in_cnt < in_cap;
    wire in_has = in_cnt != 2'd0;
    wire in_tail = in_head ^ in_cnt[0];
    wire in_auto_hit = in_fifo_wr && in_auto && in_room
        && in_load + SW'(1) == in_limit;
    wire in_sw_commit = wr_in_a && wdata_q[`UDE_IN_ARMED] && in_room
        && !in_auto_hit;
    wire in_commit = in_auto_hit || in_sw_commit;
    wire in_stall_hit = in_token && in_stall_req;
    wire in_go = in_token && !in_stall_req && in_has;
    // force: delivered without waiting for ack
    wire in_now = in_go && (in_iso || in_force);
    wire in_deliver = in_now || (in_sent && in_ack);
    wire in_drop = wr_in_a && wdata_q[`UDE_IN_DISCARD] && in_has
        && !in_deliver;
    wire in_pop = in_deliver || in_drop;
    wire [1:0] next_in_cnt = in_cnt + {1'b0, in_commit} - {1'b0, in_pop};
    // armed stays only while every slot is taken
    wire next_in_armed = next_in_cnt >= in_cap;
    wire in_raw = ((in_commit || in_deliver) && !next_in_armed)
        || in_stall_hit;
    wire in_nonempty = in_has || in_load != SW'(0);

    // OUT packet bookkeeping
    wire out_dbl = fits_two(out_limit, OUT_FIFO_BYTES);
    wire [1:0] out_cap = out_dbl ? 2'd2 : 2'd1;
    wire out_room = out_cnt < out_cap;
    wire out_waiting = out_cnt != 2'd0;
    wire out_tail = out_head ^ out_cnt[0];
    wire out_stall_hit = out_rx_done && out_stall_req;
    wire out_fresh = out_iso || out_rx_pid == out_toggle;
    wire out_accept = out_rx_done && !out_stall_req && out_room
        && out_fresh;
    wire out_dup = out_rx_done && !out_stall_req && out_room
        && !out_fresh;
    wire out_auto_hit = out_fifo_rd && out_auto && out_waiting
        && out_unload + SW'(1) == out_limit;
    // any write of control a with bit 0 low frees the head packet
    wire out_sw_rel = wr_out_a && !wdata_q[`UDE_OUT_WAITING]
        && out_waiting && !out_auto_hit;
    wire out_drop = wr_out_a && wdata_q[`UDE_OUT_DISCARD] && out_waiting
        && !out_auto_hit && !out_sw_rel;
    wire out_pop = out_auto_hit || out_sw_rel || out_drop;
    wire [1:0] next_out_cnt = out_cnt + {1'b0, out_accept}
        - {1'b0, out_pop};
    wire [SW-1:0] out_head_len = out_waiting ? out_len[out_head] : SW'(0);

    // read decode
    wire [7:0] rd_in_a = {2'b00, in_stall_done, in_stall_req, 2'b00,
        in_nonempty, in_armed};
    wire [7:0] rd_in_b = {in_auto, in_iso, 2'b00, in_force, 3'b000};
    wire [7:0] rd_out_a = {1'b0, out_stall_done, out_stall_req, 4'h0,
        out_waiting};
    wire [7:0] rd_out_b = {out_auto, out_iso, 6'h00};
    wire rd_hit = araddr == `UDE_OFS_IN_LIMIT
        || araddr == `UDE_OFS_IN_A || araddr == `UDE_OFS_IN_B
        || araddr == `UDE_OFS_OUT_LIMIT || araddr == `UDE_OFS_OUT_A
        || araddr == `UDE_OFS_OUT_B || araddr == `UDE_OFS_IRQ_EN
        || araddr == `UDE_OFS_OUT_CNT_LO
        || araddr == `UDE_OFS_OUT_CNT_HI;
    wire [31:0] rd_word =
        araddr == `UDE_OFS_IN_LIMIT ? 32'(in_limit) :
        araddr == `UDE_OFS_IN_A ? 32'(rd_in_a) :
        araddr == `UDE_OFS_IN_B ? 32'(rd_in_b) :
        araddr == `UDE_OFS_OUT_LIMIT ? 32'(out_limit) :
        araddr == `UDE_OFS_OUT_A ? 32'(rd_out_a) :
        araddr == `UDE_OFS_OUT_B ? 32'(rd_out_b) :
        araddr == `UDE_OFS_IRQ_EN ? 32'(irq_en) :
        araddr == `UDE_OFS_OUT_CNT_LO ? 32'(out_head_len[7:0]) :
        araddr == `UDE_OFS_OUT_CNT_HI ? 32'(out_head_len >> 8) :
        32'h0000_0000;

    // write channel: both halves held, then one answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `UDE_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full <= 1'b1;
                awready <= 1'b0;
            end
            if (w_take)
            begin
                w_full <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `UDE_RESP_OKAY : `UDE_RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (aw_take)
            waddr_q <= awaddr;
        if (w_take)
        begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
    end

    // read channel: reads have no side effects
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `UDE_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? `UDE_RESP_OKAY : `UDE_RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_limit <= SW'(0);
            out_limit <= SW'(0);
            {in_auto, in_iso, in_force} <= 3'b000;
            {out_auto, out_iso} <= 2'b00;
            irq_en <= 2'b00;
        end
        else
        begin
            if (wr_in_limit && lo)
                in_limit[7:0] <= wdata_q[7:0];
            if (wr_in_limit && hi)
                in_limit[SW-1:8] <= wdata_q[SW-1:8];
            if (wr_out_limit && lo)
                out_limit[7:0] <= wdata_q[7:0];
            if (wr_out_limit && hi)
                out_limit[SW-1:8] <= wdata_q[SW-1:8];
            if (wr_in_b)
                {in_auto, in_iso, in_force} <= {wdata_q[`UDE_B_AUTO],
                    wdata_q[`UDE_B_ISO], wdata_q[`UDE_INB_FORCE]};
            if (wr_out_b)
                {out_auto, out_iso} <= {wdata_q[`UDE_B_AUTO],
                    wdata_q[`UDE_B_ISO]};
            if (wr_irq)
                irq_en <= wdata_q[1:0];
        end
    end

    // stall flags: a hit in the clearing cycle still sets
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {in_stall_req, in_stall_done} <= 2'b00;
            {out_stall_req, out_stall_done} <= 2'b00;
        end
        else
        begin
            if (wr_in_a)
                in_stall_req <= wdata_q[`UDE_IN_STALL_REQ];
            in_stall_done <= in_stall_hit
                || (wr_in_a ? wdata_q[`UDE_IN_STALL_DONE] : in_stall_done);
            if (wr_out_a)
                out_stall_req <= wdata_q[`UDE_OUT_STALL_REQ];
            out_stall_done <= out_stall_hit
                || (wr_out_a ? wdata_q[`UDE_OUT_STALL_DONE]
                             : out_stall_done);
        end
    end

    // IN queue; sw commit with nothing loaded stores length 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_cnt <= 2'd0;
            in_head <= 1'b0;
            in_armed <= `UDE_RST_BIT;
            in_sent <= 1'b0;
            in_load <= SW'(0);
        end
        else
        begin
            in_cnt <= next_in_cnt;
            in_armed <= next_in_armed;
            if (in_pop)
                in_head <= ~in_head;
            if (in_commit || (in_drop == 1'b0 && wr_in_a
                && wdata_q[`UDE_IN_DISCARD] && !in_has))
                in_load <= SW'(0);
            else if (in_fifo_wr)
                in_load <= in_load + SW'(1);
            in_sent <= in_pop ? 1'b0 : (in_go && !in_now) || in_sent;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (in_commit)
            in_len[in_tail] <= in_auto_hit ? in_limit : in_load;
        if (out_accept)
            out_len[out_tail] <= out_rx_len;
    end

    // data toggles: restart wins, iso never toggles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_toggle <= 1'b0;
            out_toggle <= 1'b0;
        end
        else
        begin
            if (in_restart)
                in_toggle <= 1'b0;
            else if (in_deliver && !in_iso)
                in_toggle <= ~in_toggle;
            if (out_restart)
                out_toggle <= 1'b0;
            else if (out_accept && !out_iso)
                out_toggle <= ~out_toggle;
        end
    end

    // OUT queue
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_cnt <= 2'd0;
            out_head <= 1'b0;
            out_unload <= SW'(0);
        end
        else
        begin
            out_cnt <= next_out_cnt;
            if (out_pop)
                out_head <= ~out_head;
            if (out_pop)
                out_unload <= SW'(0);
            else if (out_fifo_rd)
                out_unload <= out_unload + SW'(1);
        end
    end

    // link answers and events, one cycle after the cause
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_resp <= UDE_RESP_NONE;
            in_resp_pid <= 1'b0;
            in_resp_len <= SW'(0);
            out_resp <= UDE_RESP_NONE;
            out_keep <= 1'b0;
            in_ep_event <= 1'b0;
            out_ep_event <= 1'b0;
        end
        else
        begin
            in_resp <= in_stall_hit ? UDE_RESP_STALL :
                in_go ? UDE_RESP_GO :
                in_token ? UDE_RESP_NAK : UDE_RESP_NONE;
            in_resp_pid <= in_toggle && !in_iso;
            in_resp_len <= in_len[in_head];
            // iso OUT has no handshake except STALL; duplicate is acked, not kept
            out_resp <= out_stall_hit ? UDE_RESP_STALL :
                !out_rx_done || out_iso ? UDE_RESP_NONE :
                !out_room ? UDE_RESP_NAK : UDE_RESP_GO;
            out_keep <= out_accept;
            in_ep_event <= irq_en[`UDE_IRQ_IN] && in_raw;
            out_ep_event <= irq_en[`UDE_IRQ_OUT]
                && (out_accept || out_stall_hit);
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_in_stall;
        in_token && in_stall_req |=> in_resp == UDE_RESP_STALL
            && in_stall_done;
    endproperty
    a_in_stall: assert property (p_in_stall)
        else $error("IN stall not answered");

    property p_out_stall;
        out_rx_done && out_stall_req |=> out_resp == UDE_RESP_STALL
            && out_stall_done && !out_keep;
    endproperty
    a_out_stall: assert property (p_out_stall)
        else $error("OUT stall not answered");

    property p_auto_arm;
        in_auto_hit && !in_pop |=> in_cnt == $past(in_cnt) + 2'd1;
    endproperty
    a_auto_arm: assert property (p_auto_arm)
        else $error("auto arm did not queue packet");

    property p_dbl_first;
        in_dbl && in_cnt == 2'd0 && in_commit
            |=> !in_armed && in_ep_event == $past(irq_en[0]);
    endproperty
    a_dbl_first: assert property (p_dbl_first)
        else $error("double buffer first packet kept armed");

    property p_single_armed;
        !in_dbl && in_cnt == 2'd0 && in_commit |=> in_armed ##1
            (in_armed || $past(in_pop));
    endproperty
    a_single_armed: assert property (p_single_armed)
        else $error("single buffer armed flag wrong");

    property p_force;
        in_go && in_force && !in_iso && !in_restart
            |=> in_toggle != $past(in_toggle);
    endproperty
    a_force: assert property (p_force)
        else $error("forced toggle did not advance");

    property p_ack_only;
        in_sent && !in_ack && !in_restart && !in_now
            |=> in_toggle == $past(in_toggle);
    endproperty
    a_ack_only: assert property (p_ack_only)
        else $error("toggle moved without ack");

    property p_restart;
        in_restart || out_restart |=> (!in_toggle || !$past(in_restart))
            && (!out_toggle || !$past(out_restart));
    endproperty
    a_restart: assert property (p_restart)
        else $error("toggle restart ignored");

    property p_out_accept;
        out_accept && !out_iso |=> out_keep && out_resp == UDE_RESP_GO
            && out_cnt != 2'd0;
    endproperty
    a_out_accept: assert property (p_out_accept)
        else $error("received packet not flagged");

    property p_auto_release;
        out_auto_hit && !out_accept |=> out_cnt == $past(out_cnt) - 2'd1;
    endproperty
    a_auto_release: assert property (p_auto_release)
        else $error("auto release did not free packet");

    property p_dup;
        out_dup && !out_iso |=> !out_keep && out_resp == UDE_RESP_GO;
    endproperty
    a_dup: assert property (p_dup)
        else $error("repeated toggle packet kept");

    c_dbl_full: cover property (in_dbl && in_cnt == 2'd2);
    c_stall: cover property (in_resp == UDE_RESP_STALL);
    c_zlp: cover property (in_resp == UDE_RESP_GO && in_resp_len == 0);
    c_out_two: cover property (out_cnt == 2'd2 ##1 out_pop);

endmodule

// ### ude_cfg.svh
/*
 * register offsets, field positions, reset values and bus answers
 * of the data endpoint control block.
 * assumes byte addresses on an 8-bit AXI4-Lite address, one word each.
 */
`ifndef UDE_CFG_SVH
`define UDE_CFG_SVH

`define UDE_OFS_IN_LIMIT 8'h00
`define UDE_OFS_IN_A 8'h04
`define UDE_OFS_IN_B 8'h08
`define UDE_OFS_OUT_LIMIT 8'h0C
`define UDE_OFS_OUT_A 8'h10
`define UDE_OFS_OUT_B 8'h14
`define UDE_OFS_OUT_CNT_LO 8'h18
`define UDE_OFS_OUT_CNT_HI 8'h1C
`define UDE_OFS_IRQ_EN 8'h20

`define UDE_IN_ARMED 0
`define UDE_IN_NONEMPTY 1
`define UDE_IN_DISCARD 3
`define UDE_IN_STALL_REQ 4
`define UDE_IN_STALL_DONE 5
`define UDE_IN_RESTART 6
`define UDE_INB_FORCE 3
`define UDE_OUT_WAITING 0
`define UDE_OUT_DISCARD 4
`define UDE_OUT_STALL_REQ 5
`define UDE_OUT_STALL_DONE 6
`define UDE_OUT_RESTART 7
`define UDE_B_ISO 6
`define UDE_B_AUTO 7
`define UDE_IRQ_IN 0
`define UDE_IRQ_OUT 1

`define UDE_RST_BIT 1'b0
`define UDE_RESP_OKAY 2'b00
`define UDE_RESP_SLVERR 2'b10

`endif

// ### ude_pkg.sv
/*
 * types of the data endpoint control block.
 * assumes nothing of its surroundings.
 */
package ude_pkg;

    // handshake the link engine is told to send, one-hot
    typedef enum logic [3:0]
    {
        UDE_RESP_NONE = 4'b0001,
        UDE_RESP_NAK = 4'b0010,
        UDE_RESP_GO = 4'b0100,
        UDE_RESP_STALL = 4'b1000
    } ude_resp_t;

endpackage

// ### ude_host.sv
/* usb host model facing the endpoint block's link side.
   assumes the block answers one cycle after each pulse. */
`timescale 1ns/1ps
module ude_host
import ude_pkg::*;
#(parameter int SW = 11)(
    // clock
    input wire logic aclk,
    // IN link
    output logic in_token,
    output logic in_ack,
    input wire ude_pkg::ude_resp_t in_resp,
    input wire logic in_resp_pid,
    input wire logic [SW-1:0] in_resp_len,
    // OUT link
    output logic out_rx_done,
    output logic out_rx_pid,
    output logic [SW-1:0] out_rx_len,
    input wire ude_pkg::ude_resp_t out_resp,
    input wire logic out_keep
);
    initial
    begin
        in_token = 1'b0;
        in_ack = 1'b0;
        out_rx_done = 1'b0;
        out_rx_pid = 1'b0;
        out_rx_len = '0;
    end
    // token, answer one cycle later, optional ack
    task in_tr(input logic ak, output ude_resp_t r, output logic p,
        output logic [SW-1:0] n);
        in_token <= 1'b1;
        @(posedge aclk);
        in_token <= 1'b0;
        @(posedge aclk);
        r = in_resp;
        p = in_resp_pid;
        n = in_resp_len;
        if (ak)
        begin
            in_ack <= 1'b1;
            @(posedge aclk);
            in_ack <= 1'b0;
        end
    endtask
    // released fields flip so stale values never look valid
    task out_tr(input logic p, input logic [SW-1:0] n,
        output ude_resp_t r, output logic k);
        out_rx_done <= 1'b1;
        out_rx_pid <= p;
        out_rx_len <= n;
        @(posedge aclk);
        out_rx_done <= 1'b0;
        out_rx_pid <= ~p;
        out_rx_len <= ~n;
        @(posedge aclk);
        r = out_resp;
        k = out_keep;
    endtask
endmodule

// ### ude_endpoint_ctrl_tb.sv
/* self-checking bench of the data endpoint control block.
   assumes the design files and the host model are compiled first. */
`timescale 1ns/1ps
`include "ude_cfg.svh"
module ude_endpoint_ctrl_tb;
import ude_pkg::*;
logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready, in_fifo_wr, out_fifo_rd;
logic in_token, in_ack, in_resp_pid, out_rx_done, out_rx_pid, out_keep;
logic in_ep_event, out_ep_event;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, rdata;
logic [3:0] wstrb;
logic [1:0] bresp, rresp;
logic [10:0] in_resp_len, out_rx_len;
ude_resp_t in_resp, out_resp;
int bad_count, n_compared;
int in_ev_n, out_ev_n;
// events are one-cycle pulses: count them as they stand
always @(posedge aclk)
begin
    if (in_ep_event === 1'b1) in_ev_n++;
    if (out_ep_event === 1'b1) out_ev_n++;
end
ude_endpoint_ctrl u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .in_fifo_wr,
    .out_fifo_rd, .in_token, .in_ack, .in_resp, .in_resp_pid, .in_resp_len,
    .out_rx_done, .out_rx_pid, .out_rx_len, .out_resp, .out_keep,
    .in_ep_event, .out_ep_event);
ude_host u_host (.aclk, .in_token, .in_ack, .in_resp, .in_resp_pid,
    .in_resp_len, .out_rx_done, .out_rx_pid, .out_rx_len, .out_resp,
    .out_keep);
task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", s, e, g);
    end
endtask
task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
endtask
task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", 32'(`UDE_RESP_OKAY), 32'(r));
endtask
task rdx(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(s, e, d);
    chk("rresp", 32'(`UDE_RESP_OKAY), 32'(r));
endtask
task load(input int n);
    repeat (n)
    begin
        in_fifo_wr <= 1'b1;
        @(posedge aclk);
    end
    in_fifo_wr <= 1'b0;
endtask
// pid and length only mean something beside a data answer
task tin(input logic ak, input ude_resp_t er, input logic ep,
    input logic [10:0] el);
    ude_resp_t r;
    logic p;
    logic [10:0] n;
    u_host.in_tr(ak, r, p, n);
    chk("in_resp", 32'(er), 32'(r));
    if (er === UDE_RESP_GO)
    begin
        chk("in_pid", 32'(ep), 32'(p));
        chk("in_len", 32'(el), 32'(n));
    end
endtask
task tout(input logic p, input logic [10:0] n, input ude_resp_t er,
    input logic ek);
    ude_resp_t r;
    logic k;
    u_host.out_tr(p, n, r, k);
    chk("out_resp", 32'(er), 32'(r));
    if (er === UDE_RESP_GO) chk("out_keep", 32'(ek), 32'(k));
endtask
task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdx(`UDE_OFS_IN_A, 32'h0, "in_a reset");
    axi_rd(8'h40, d, r);
    chk("unmapped rresp", 32'(`UDE_RESP_SLVERR), 32'(r));
    axi_wr(8'h40, 32'hFF, r);
    chk("unmapped bresp", 32'(`UDE_RESP_SLVERR), 32'(r));
    $display("test regs done");
endtask
task t_in;
    wr(`UDE_OFS_IN_LIMIT, 32'h40);
    wr(`UDE_OFS_IRQ_EN, 32'h3);
    load(5);
    wr(`UDE_OFS_IN_A, 32'h1);
    rdx(`UDE_OFS_IN_A, 32'h3, "armed queued");
    tin(1'b1, UDE_RESP_GO, 1'b0, 11'h5);
    rdx(`UDE_OFS_IN_A, 32'h0, "armed sent");
    wr(`UDE_OFS_IN_A, 32'h1);
    tin(1'b1, UDE_RESP_GO, 1'b1, 11'h0);
    $display("test in done");
endtask
task t_in_stall;
    wr(`UDE_OFS_IN_A, 32'h10);
    tin(1'b0, UDE_RESP_STALL, 1'b0, 11'h0);
    rdx(`UDE_OFS_IN_A, 32'h30, "in stall flag");
    wr(`UDE_OFS_IN_A, 32'h40);
    wr(`UDE_OFS_IN_B, 32'h08);
    // no acks sent: only the forced advance can flip the pid
    for (int i = 0; i < 2; i++)
    begin
        load(1);
        wr(`UDE_OFS_IN_A, 32'h1);
        tin(1'b0, UDE_RESP_GO, i[0], 11'h1);
    end
    $display("test in stall done");
endtask
task t_auto;
    wr(`UDE_OFS_IN_B, 32'h80);
    wr(`UDE_OFS_IN_LIMIT, 32'h4);
    load(4);
    rdx(`UDE_OFS_IN_A, 32'h2, "double buf armed");
    tin(1'b1, UDE_RESP_GO, 1'b0, 11'h4);
    $display("test auto done");
endtask
task t_out;
    wr(`UDE_OFS_OUT_LIMIT, 32'h40);
    tout(1'b0, 11'h7, UDE_RESP_GO, 1'b1);
    rdx(`UDE_OFS_OUT_A, 32'h1, "out waiting");
    rdx(`UDE_OFS_OUT_CNT_LO, 32'h7, "out count");
    wr(`UDE_OFS_OUT_A, 32'h0);
    tout(1'b0, 11'h7, UDE_RESP_GO, 1'b0);
    wr(`UDE_OFS_OUT_B, 32'h80);
    wr(`UDE_OFS_OUT_LIMIT, 32'h4);
    tout(1'b1, 11'h4, UDE_RESP_GO, 1'b1);
    repeat (4)
    begin
        out_fifo_rd <= 1'b1;
        @(posedge aclk);
    end
    out_fifo_rd <= 1'b0;
    rdx(`UDE_OFS_OUT_A, 32'h0, "auto release");
    wr(`UDE_OFS_OUT_A, 32'h20);
    tout(1'b0, 11'h1, UDE_RESP_STALL, 1'b0);
    rdx(`UDE_OFS_OUT_A, 32'h60, "out stall flag");
    $display("test out done");
endtask
task t_misc;
    tin(1'b0, UDE_RESP_NAK, 1'b0, 11'h0);
    load(2);
    wr(`UDE_OFS_IN_A, 32'h1);
    rdx(`UDE_OFS_IN_A, 32'h2, "in queued");
    wr(`UDE_OFS_IN_A, 32'h8);
    rdx(`UDE_OFS_IN_A, 32'h0, "in discard");
    wr(`UDE_OFS_IN_B, 32'hC0);
    load(4);
    tin(1'b0, UDE_RESP_GO, 1'b0, 11'h4);
    wr(`UDE_OFS_OUT_A, 32'h80);
    tout(1'b0, 11'h4, UDE_RESP_GO, 1'b1);
    // without the restart this pid would repeat and be dropped
    wr(`UDE_OFS_OUT_A, 32'h80);
    tout(1'b0, 11'h4, UDE_RESP_GO, 1'b1);
    @(posedge aclk);
    chk("in events", 32'hA, 32'(in_ev_n));
    chk("out events", 32'h5, 32'(out_ev_n));
    $display("test misc done");
endtask
task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
initial
begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
end
initial
begin
    {aresetn, awvalid, wvalid, arvalid, in_fifo_wr, out_fifo_rd} = '0;
    {awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_in();
    t_in_stall();
    t_auto();
    t_out();
    t_misc();
    complete_run();
end
// whole run is about 150 cycles
initial
begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    complete_run();
end
endmodule
